// >>> rtl/lrac_consts.svh
// Constants of the logger clock, alarm and mission control block.
// Assumes a 50 MHz clk; included by the package and the control module.
`ifndef LRAC_CONSTS_SVH
`define LRAC_CONSTS_SVH
`define LRAC_OFS_SEC 8'h00
`define LRAC_OFS_MIN 8'h01
`define LRAC_OFS_HOUR 8'h02
`define LRAC_OFS_DAY 8'h03
`define LRAC_OFS_DATE 8'h04
`define LRAC_OFS_MONTH 8'h05
`define LRAC_OFS_YEAR 8'h06
`define LRAC_OFS_ASEC 8'h07
`define LRAC_OFS_AMIN 8'h08
`define LRAC_OFS_AHOUR 8'h09
`define LRAC_OFS_ADAY 8'h0A
`define LRAC_OFS_CTRL1 8'h0E
`define LRAC_OFS_RATE 8'h0F
`define LRAC_OFS_DLY_LO 8'h10
`define LRAC_OFS_DLY_HI 8'h11
`define LRAC_OFS_STATUS 8'h14
`define LRAC_MASK_SEC 8'h7F
`define LRAC_MASK_HOUR 8'h7F
`define LRAC_MASK_DAY 8'h07
`define LRAC_MASK_DATE 8'h3F
`define LRAC_MASK_MONTH 8'h1F
`define LRAC_MASK_ADAY 8'h87
`define LRAC_MASK_CTRL1 8'hDF
`define LRAC_BIT_AMASK 7
`define LRAC_BIT_12H 6
`define LRAC_BIT_PM 5
`define LRAC_BIT_OSC_STOP 7
`define LRAC_BIT_CLR_ARM 6
`define LRAC_BIT_START_EN 4
`define LRAC_BIT_WRAP 3
`define LRAC_BIT_TL 2
`define LRAC_BIT_TH 1
`define LRAC_BIT_ALM 0
`define LRAC_BIT_MEMCLR 6
`define LRAC_BIT_MIP 5
`define LRAC_BIT_LOBAT 3
`define LRAC_RST_ZERO 8'h00
`define LRAC_RST_ONE 8'h01
`define LRAC_CLK_HZ 50000000
`define LRAC_SEC_MS 1000
`define LRAC_HALF_SEC_MS 500
`define LRAC_PULSE_US 62500
`define LRAC_SEC_CYC (`LRAC_CLK_HZ / 1000 * `LRAC_SEC_MS)
`define LRAC_HALF_CYC (`LRAC_CLK_HZ / 1000 * `LRAC_HALF_SEC_MS)
`define LRAC_PULSE_CYC (`LRAC_CLK_HZ / 1000000 * `LRAC_PULSE_US)
`define LRAC_PULSES 3'd4
`define LRAC_LOG_LAST 11'h7FF
`endif

// >>> rtl/lrac_pkg.sv
// Types shared by the logger control block and its bench.
// Assumes lrac_consts.svh is on the include path.
`include "lrac_consts.svh"
package lrac_pkg;
  typedef enum logic [1:0] {
    CMD_OTHER = 2'b00,
    CMD_SPEC_TEST = 2'b01,
    CMD_CLEAR_MEM = 2'b10
  } lrac_cmd_t;
  typedef enum logic [1:0] {
    PAT_BOTH = 2'b00,
    PAT_IN = 2'b01,
    PAT_OUT = 2'b10,
    PAT_ALT = 2'b11
  } lrac_pattern_t;
  typedef enum logic {
    IND_IDLE = 1'b0,
    IND_RUN = 1'b1
  } lrac_ind_state_t;
endpackage

// >>> rtl/lrac_rtc_alarm_control.sv
// Clock/calendar, alarm, mission control and indicator sequencer of the logger.
// Assumes the conversion datapath reports each finished sample and stores it at logWrAddr.
`timescale 1ns/1ps
`default_nettype none
`include "lrac_consts.svh"
module lrac_rtc_alarm_control #(
  parameter int unsigned SEC_CYCLES = `LRAC_SEC_CYC,
  parameter int unsigned HALF_CYCLES = `LRAC_HALF_CYC,
  parameter int unsigned PULSE_CYCLES = `LRAC_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Command port
  input wire logic cmdValid,
  input wire lrac_pkg::lrac_cmd_t cmdCode,
  // Pins and supply status
  input wire logic startStatusInputN,
  input wire logic mainPowerOk,
  input wire logic lowBattery,
  output logic inLimitsIndicatorN,
  output logic outOfLimitsIndicatorN,
  output logic irqN,
  output logic oscRunning,
  // Sampling datapath
  output logic sampleRequest,
  input wire logic sampleDone,
  input wire logic sampleTempLow,
  input wire logic sampleTempHigh,
  input wire logic sampleAdcOut,
  output logic logWrEn,
  output logic [10:0] logWrAddr,
  output logic memClearPulse
);
  import lrac_pkg::*;

  function automatic logic [7:0] bcdNext(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    if (v == last)
      bcdNext = first;
    else if (v[3:0] == 4'h9)
      bcdNext = {v[7:4] + 4'h1, 4'h0};
    else
      bcdNext = {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] monthLast(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      8'h02: monthLast = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: monthLast = 8'h30;
      default: monthLast = 8'h31;
    endcase
  endfunction

  logic [7:0] sec_q, min_q, hour_q, day_q, date_q, month_q, year_q;
  logic [7:0] aSec_q, aMin_q, aHour_q, aDay_q;
  logic [7:0] ctrl1_q, rate_q;
  logic [15:0] delay_q;
  logic [25:0] tickCnt_q;
  logic secTick_q, tickDly_q;
  logic mip_q, memCleared_q, firstDone_q, anyOut_q;
  logic tlf_q, thf_q, tod_alarm_flag_q;
  logic [7:0] minCnt_q;
  logic [10:0] logPtr_q;
  logic logFull_q;
  logic [23:0] sampleCount_q;
  logic [25:0] stCnt_q;
  logic stHeld;
  logic [7:0] hourNext;
  logic [7:0] hour12Inc, hour24Inc;
  logic dayRoll, minuteRoll, oscRun, alarmHit;
  logic wrSel, ctrlWrite, statusWrite, clearDo, missionStart, missionStop, statusReq;
  lrac_ind_state_t indState_q;
  lrac_pattern_t pattern_q;
  logic [2:0] pulseIdx_q;
  logic [25:0] phaseCnt_q;

  assign wrSel = regWrEn;
  assign ctrlWrite = wrSel && regAddr < `LRAC_OFS_STATUS;
  assign statusWrite = wrSel && regAddr == `LRAC_OFS_STATUS;
  assign clearDo = cmdValid && cmdCode == CMD_CLEAR_MEM && ctrl1_q[`LRAC_BIT_CLR_ARM];

  // Backup mode may park the oscillator, but never while power is up or logging runs.
  assign oscRun = mainPowerOk || mip_q || !ctrl1_q[`LRAC_BIT_OSC_STOP];
  assign oscRunning = oscRun;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tickCnt_q <= 26'h0;
      secTick_q <= 1'b0;
      tickDly_q <= 1'b0;
    end
    else
    begin
      secTick_q <= 1'b0;
      tickDly_q <= secTick_q;
      if (oscRun)
      begin
        if (tickCnt_q == 26'(SEC_CYCLES - 1))
        begin
          tickCnt_q <= 26'h0;
          secTick_q <= 1'b1;
        end
        else
          tickCnt_q <= tickCnt_q + 26'h1;
      end
    end
  end

  assign minuteRoll = secTick_q && sec_q == 8'h59;
  assign hour12Inc = bcdNext({3'b000, hour_q[4:0]}, 8'h12, 8'h01);
  assign hour24Inc = bcdNext({2'b00, hour_q[5:0]}, 8'h23, 8'h00);

  always_comb
  begin
    hourNext = hour_q;
    dayRoll = 1'b0;
    if (hour_q[`LRAC_BIT_12H])
    begin
      if (hour_q[4:0] == 5'h11)
      begin
        hourNext = {2'b01, ~hour_q[`LRAC_BIT_PM], 5'h12};
        dayRoll = hour_q[`LRAC_BIT_PM];
      end
      else if (hour_q[4:0] == 5'h12)
        hourNext = {2'b01, hour_q[`LRAC_BIT_PM], 5'h01};
      else
        hourNext = {2'b01, hour_q[`LRAC_BIT_PM], hour12Inc[4:0]};
    end
    else
    begin
      hourNext = {2'b00, hour24Inc[5:0]};
      dayRoll = hour_q[5:0] == 6'h23;
    end
  end

  // Host writes take precedence over the second tick, so a set time is never bumped.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sec_q <= `LRAC_RST_ZERO;
      min_q <= `LRAC_RST_ZERO;
      hour_q <= `LRAC_RST_ZERO;
      day_q <= `LRAC_RST_ONE;
      date_q <= `LRAC_RST_ONE;
      month_q <= `LRAC_RST_ONE;
      year_q <= `LRAC_RST_ZERO;
    end
    else if (wrSel)
    begin
      unique case (regAddr)
        `LRAC_OFS_SEC: sec_q <= regWrData & `LRAC_MASK_SEC;
        `LRAC_OFS_MIN: min_q <= regWrData & `LRAC_MASK_SEC;
        `LRAC_OFS_HOUR: hour_q <= regWrData & `LRAC_MASK_HOUR;
        `LRAC_OFS_DAY: day_q <= regWrData & `LRAC_MASK_DAY;
        `LRAC_OFS_DATE: date_q <= regWrData & `LRAC_MASK_DATE;
        `LRAC_OFS_MONTH: month_q <= regWrData & `LRAC_MASK_MONTH;
        `LRAC_OFS_YEAR: year_q <= regWrData;
        default: ;
      endcase
    end
    else if (secTick_q)
    begin
      sec_q <= bcdNext(sec_q, 8'h59, 8'h00);
      if (sec_q == 8'h59)
      begin
        min_q <= bcdNext(min_q, 8'h59, 8'h00);
        if (min_q == 8'h59)
        begin
          hour_q <= hourNext;
          if (dayRoll)
          begin
            day_q <= bcdNext(day_q, 8'h07, 8'h01);
            date_q <= bcdNext(date_q, monthLast(month_q, year_q), 8'h01);
            if (date_q == monthLast(month_q, year_q))
            begin
              month_q <= bcdNext(month_q, 8'h12, 8'h01);
              if (month_q == 8'h12)
                year_q <= bcdNext(year_q, 8'h99, 8'h00);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aSec_q <= `LRAC_RST_ZERO;
      aMin_q <= `LRAC_RST_ZERO;
      aHour_q <= `LRAC_RST_ZERO;
      aDay_q <= `LRAC_RST_ZERO;
    end
    else if (wrSel)
    begin
      unique case (regAddr)
        `LRAC_OFS_ASEC: aSec_q <= regWrData;
        `LRAC_OFS_AMIN: aMin_q <= regWrData;
        `LRAC_OFS_AHOUR: aHour_q <= regWrData;
        `LRAC_OFS_ADAY: aDay_q <= regWrData & `LRAC_MASK_ADAY;
        default: ;
      endcase
    end
  end

  // Compared one cycle after the tick, against the freshly advanced time.
  assign alarmHit = tickDly_q
    && (aSec_q[`LRAC_BIT_AMASK] || aSec_q[6:0] == sec_q[6:0])
    && (aMin_q[`LRAC_BIT_AMASK] || aMin_q[6:0] == min_q[6:0])
    && (aHour_q[`LRAC_BIT_AMASK] || aHour_q[6:0] == hour_q[6:0])
    && (aDay_q[`LRAC_BIT_AMASK] || aDay_q[2:0] == day_q[2:0]);

  // A flag event in the same cycle as a host clear keeps the flag set.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tlf_q <= 1'b0;
      thf_q <= 1'b0;
      tod_alarm_flag_q <= 1'b0;
    end
    else
    begin
      tlf_q <= (sampleDone && sampleTempLow) || (tlf_q && !(statusWrite && !regWrData[`LRAC_BIT_TL]));
      thf_q <= (sampleDone && sampleTempHigh) || (thf_q && !(statusWrite && !regWrData[`LRAC_BIT_TH]));
      tod_alarm_flag_q <= alarmHit || (tod_alarm_flag_q && !(statusWrite && !regWrData[`LRAC_BIT_ALM]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irqN <= 1'b1;
    else
      irqN <= !((tlf_q && ctrl1_q[`LRAC_BIT_TL])
        || (thf_q && ctrl1_q[`LRAC_BIT_TH])
        || (tod_alarm_flag_q && ctrl1_q[`LRAC_BIT_ALM]));
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl1_q <= `LRAC_RST_ZERO;
    else if (wrSel && regAddr == `LRAC_OFS_CTRL1)
      ctrl1_q <= regWrData & `LRAC_MASK_CTRL1;
    else if (cmdValid)
      ctrl1_q[`LRAC_BIT_CLR_ARM] <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stCnt_q <= 26'h0;
      stHeld <= 1'b0;
    end
    else
    begin
      stHeld <= 1'b0;
      if (startStatusInputN)
        stCnt_q <= 26'h0;
      else if (stCnt_q != 26'(HALF_CYCLES))
      begin
        stCnt_q <= stCnt_q + 26'h1;
        stHeld <= stCnt_q == 26'(HALF_CYCLES - 1);
      end
    end
  end

  assign missionStart = !mip_q && !clearDo && (
    (!ctrl1_q[`LRAC_BIT_START_EN] && wrSel && regAddr == `LRAC_OFS_RATE && memCleared_q && regWrData != 8'h00)
    || (ctrl1_q[`LRAC_BIT_START_EN] && stHeld && rate_q != 8'h00));
  assign missionStop = clearDo || (mip_q && ctrlWrite)
    || (statusWrite && !regWrData[`LRAC_BIT_MIP]);
  assign statusReq = (cmdValid && cmdCode == CMD_SPEC_TEST) || (mip_q && stHeld);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mip_q <= 1'b0;
      memCleared_q <= 1'b1;
    end
    else
    begin
      if (missionStart)
        mip_q <= 1'b1;
      else if (missionStop)
        mip_q <= 1'b0;
      if (clearDo)
        memCleared_q <= 1'b1;
      else if (missionStart)
        memCleared_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || clearDo)
    begin
      rate_q <= `LRAC_RST_ZERO;
      delay_q <= 16'h0000;
    end
    else
    begin
      if (wrSel && regAddr == `LRAC_OFS_RATE && memCleared_q)
        rate_q <= regWrData;
      if (wrSel && regAddr == `LRAC_OFS_DLY_LO)
        delay_q[7:0] <= regWrData;
      else if (wrSel && regAddr == `LRAC_OFS_DLY_HI)
        delay_q[15:8] <= regWrData;
      else if (mip_q && !firstDone_q && minuteRoll && delay_q != 16'h0000)
        delay_q <= delay_q - 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || clearDo || missionStart)
    begin
      sampleRequest <= 1'b0;
      firstDone_q <= 1'b0;
      minCnt_q <= 8'h00;
    end
    else
    begin
      sampleRequest <= 1'b0;
      if (mip_q && minuteRoll)
      begin
        if (!firstDone_q)
        begin
          if (delay_q == 16'h0000)
          begin
            sampleRequest <= 1'b1;
            firstDone_q <= 1'b1;
          end
        end
        else if (minCnt_q + 8'h01 == rate_q)
        begin
          sampleRequest <= 1'b1;
          minCnt_q <= 8'h00;
        end
        else
          minCnt_q <= minCnt_q + 8'h01;
      end
    end
  end

  // With wrap off the pointer still rolls to zero, but the full flag blocks further stores.
  always_ff @(posedge clk)
  begin
    if (reset || clearDo)
    begin
      logPtr_q <= 11'h000;
      logFull_q <= 1'b0;
      logWrEn <= 1'b0;
      logWrAddr <= 11'h000;
      sampleCount_q <= 24'h000000;
      anyOut_q <= 1'b0;
    end
    else
    begin
      logWrEn <= 1'b0;
      if (sampleDone && mip_q)
      begin
        sampleCount_q <= sampleCount_q + 24'h000001;
        anyOut_q <= anyOut_q || sampleTempLow || sampleTempHigh || sampleAdcOut;
        if (!logFull_q || ctrl1_q[`LRAC_BIT_WRAP])
        begin
          logWrEn <= 1'b1;
          logWrAddr <= logPtr_q;
          logPtr_q <= logPtr_q + 11'h001;
          if (logPtr_q == `LRAC_LOG_LAST && !ctrl1_q[`LRAC_BIT_WRAP])
            logFull_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      memClearPulse <= 1'b0;
    else
      memClearPulse <= clearDo;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      indState_q <= IND_IDLE;
      pattern_q <= PAT_BOTH;
      pulseIdx_q <= 3'd0;
      phaseCnt_q <= 26'h0;
    end
    else
    begin
      unique case (indState_q)
        IND_IDLE:
        begin
          phaseCnt_q <= 26'h0;
          pulseIdx_q <= 3'd0;
          if (missionStart)
          begin
            indState_q <= IND_RUN;
            pattern_q <= PAT_BOTH;
          end
          else if (statusReq)
          begin
            indState_q <= IND_RUN;
            if (mip_q && sampleCount_q == 24'h000000)
              pattern_q <= PAT_ALT;
            else if (anyOut_q)
              pattern_q <= PAT_OUT;
            else
              pattern_q <= PAT_IN;
          end
        end
        IND_RUN:
        begin
          if (phaseCnt_q == 26'(HALF_CYCLES - 1))
          begin
            phaseCnt_q <= 26'h0;
            pulseIdx_q <= pulseIdx_q + 3'd1;
            if (pulseIdx_q == `LRAC_PULSES - 3'd1)
              indState_q <= IND_IDLE;
          end
          else
            phaseCnt_q <= phaseCnt_q + 26'h1;
        end
      endcase
    end
  end

  // Requests that arrive while a sequence runs are dropped rather than queued.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      inLimitsIndicatorN <= 1'b1;
      outOfLimitsIndicatorN <= 1'b1;
    end
    else
    begin
      inLimitsIndicatorN <= 1'b1;
      outOfLimitsIndicatorN <= 1'b1;
      if (indState_q == IND_RUN && phaseCnt_q < 26'(PULSE_CYCLES))
      begin
        unique case (pattern_q)
          PAT_BOTH:
          begin
            inLimitsIndicatorN <= 1'b0;
            outOfLimitsIndicatorN <= 1'b0;
          end
          PAT_IN: inLimitsIndicatorN <= 1'b0;
          PAT_OUT: outOfLimitsIndicatorN <= 1'b0;
          PAT_ALT:
          begin
            outOfLimitsIndicatorN <= pulseIdx_q[0];
            inLimitsIndicatorN <= !pulseIdx_q[0];
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      regRdData <= 8'h00;
    else
    begin
      unique case (regAddr)
        `LRAC_OFS_SEC: regRdData <= sec_q;
        `LRAC_OFS_MIN: regRdData <= min_q;
        `LRAC_OFS_HOUR: regRdData <= hour_q;
        `LRAC_OFS_DAY: regRdData <= day_q;
        `LRAC_OFS_DATE: regRdData <= date_q;
        `LRAC_OFS_MONTH: regRdData <= month_q;
        `LRAC_OFS_YEAR: regRdData <= year_q;
        `LRAC_OFS_ASEC: regRdData <= aSec_q;
        `LRAC_OFS_AMIN: regRdData <= aMin_q;
        `LRAC_OFS_AHOUR: regRdData <= aHour_q;
        `LRAC_OFS_ADAY: regRdData <= aDay_q;
        `LRAC_OFS_CTRL1: regRdData <= ctrl1_q;
        `LRAC_OFS_RATE: regRdData <= rate_q;
        `LRAC_OFS_DLY_LO: regRdData <= delay_q[7:0];
        `LRAC_OFS_DLY_HI: regRdData <= delay_q[15:8];
        `LRAC_OFS_STATUS: regRdData <= {1'b0, memCleared_q, mip_q, 1'b0, lowBattery, tlf_q, thf_q, tod_alarm_flag_q};
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule // lrac_rtc_alarm_control
`default_nettype wire

// >>> test/lrac_rtc_alarm_control_properties.sv
// Port checker for the logger clock and mission control block.
// Assumes the bind below and the package on the compile list.
`timescale 1ns/1ps
`default_nettype none
`include "lrac_consts.svh"
module lrac_rtc_alarm_control_properties
  import lrac_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic cmdValid,
  input wire lrac_pkg::lrac_cmd_t cmdCode,
  input wire logic mainPowerOk,
  input wire logic oscRunning,
  input wire logic inLimitsIndicatorN,
  input wire logic outOfLimitsIndicatorN,
  input wire logic memClearPulse,
  input wire logic sampleRequest,
  input wire logic sampleDone,
  input wire logic logWrEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Low-time counters let one assertion check the full pulse width.
  logic [31:0] inLo_q;
  logic [31:0] outLo_q;
  always_ff @(posedge clk) inLo_q <= (reset || inLimitsIndicatorN) ? 32'h0 : inLo_q + 32'h1;
  always_ff @(posedge clk) outLo_q <= (reset || outOfLimitsIndicatorN) ? 32'h0 : outLo_q + 32'h1;
  property p_in_len; $rose(inLimitsIndicatorN) |-> inLo_q == PULSE_CYCLES; endproperty
  a_in_len: assert property (p_in_len) else $error("in-limits pulse width wrong");
  property p_out_len; $rose(outOfLimitsIndicatorN) |-> outLo_q == PULSE_CYCLES; endproperty
  a_out_len: assert property (p_out_len) else $error("out-of-limits pulse width wrong");
  property p_in_gap; $rose(inLimitsIndicatorN) |-> inLimitsIndicatorN [*8]; endproperty
  a_in_gap: assert property (p_in_gap) else $error("in-limits pulses too close");
  property p_mem_clr; memClearPulse |-> $past(cmdValid) && $past(cmdCode) == CMD_CLEAR_MEM; endproperty
  a_mem_clr: assert property (p_mem_clr) else $error("memory clear without command");
  property p_clr_once; memClearPulse |=> !memClearPulse; endproperty
  a_clr_once: assert property (p_clr_once) else $error("memory clear longer than one cycle");
  property p_log_wr; logWrEn |-> $past(sampleDone); endproperty
  a_log_wr: assert property (p_log_wr) else $error("datalog write without sample");
  property p_sec_zero; $past(regAddr) == `LRAC_OFS_SEC |-> !regRdData[7]; endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("seconds fixed bit set");
  property p_day_zero; $past(regAddr) == `LRAC_OFS_DAY |-> regRdData[7:3] == 5'h00; endproperty
  a_day_zero: assert property (p_day_zero) else $error("day fixed bits set");
  property p_osc; mainPowerOk |-> oscRunning; endproperty
  a_osc: assert property (p_osc) else $error("oscillator stopped on main power");
  property p_req; sampleRequest |=> !sampleRequest; endproperty
  a_req: assert property (p_req) else $error("sample request too long");
  c_in: cover property ($fell(inLimitsIndicatorN));
  c_clr: cover property (memClearPulse);
  c_log: cover property (logWrEn);
endmodule // lrac_rtc_alarm_control_properties
bind lrac_rtc_alarm_control lrac_rtc_alarm_control_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .clk(clk), .reset(reset), .regAddr(regAddr), .regRdData(regRdData), .cmdValid(cmdValid),
  .cmdCode(cmdCode), .mainPowerOk(mainPowerOk), .oscRunning(oscRunning),
  .inLimitsIndicatorN(inLimitsIndicatorN), .outOfLimitsIndicatorN(outOfLimitsIndicatorN),
  .memClearPulse(memClearPulse), .sampleRequest(sampleRequest), .sampleDone(sampleDone), .logWrEn(logWrEn)
);
`default_nettype wire

// >>> test/lrac_sampler_model.sv
// Stand-in for the conversion datapath that answers sample requests.
// Assumes one request at a time; violate picks the reported outcome.
`timescale 1ns/1ps
`default_nettype none
module lrac_sampler_model #(
  parameter int LATENCY = 3
) (
  input wire logic clk,
  input wire logic sampleRequest,
  input wire logic violate,
  output logic sampleDone,
  output logic tempLow,
  output logic tempHigh,
  output logic adcOut
);
  int cnt = 0;
  initial
  begin
    sampleDone = 1'b0;
    tempLow = 1'b0;
    tempHigh = 1'b0;
    adcOut = 1'b0;
  end
  // Qualifiers toggle outside a done cycle so a design sampling them late sees junk.
  always @(posedge clk)
  begin
    cnt <= sampleRequest ? LATENCY : (cnt > 0 ? cnt - 1 : 0);
    sampleDone <= (cnt == 1);
    tempHigh <= (cnt == 1) ? violate : ~tempHigh;
    tempLow <= (cnt == 1) ? 1'b0 : ~tempLow;
    adcOut <= (cnt == 1) ? 1'b0 : ~adcOut;
  end
endmodule // lrac_sampler_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench of the logger control block.
// Assumes the checker is bound and the sampler model stands for the datapath.
`timescale 1ns/1ps
`default_nettype none
`include "lrac_consts.svh"
module testbench;
  import lrac_pkg::*;
  logic clk, reset, regWrEn, cmdValid, startN, violate, inN, outN, irqN, osc, pwrOk;
  logic sReq, sDone, tLow, tHigh, aOut, logWrEn, memClr;
  logic [7:0] regAddr, regWrData, regRdData, v;
  logic [10:0] logWrAddr;
  lrac_cmd_t cmdCode;
  int fails = 0;
  int checks = 0;
  lrac_rtc_alarm_control #(.SEC_CYCLES(40), .HALF_CYCLES(20), .PULSE_CYCLES(5)) dut (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdData(regRdData), .cmdValid(cmdValid), .cmdCode(cmdCode), .startStatusInputN(startN),
    .mainPowerOk(pwrOk), .lowBattery(1'b0), .inLimitsIndicatorN(inN), .outOfLimitsIndicatorN(outN),
    .irqN(irqN), .oscRunning(osc), .sampleRequest(sReq), .sampleDone(sDone), .sampleTempLow(tLow),
    .sampleTempHigh(tHigh), .sampleAdcOut(aOut), .logWrEn(logWrEn), .logWrAddr(logWrAddr), .memClearPulse(memClr)
  );
  lrac_sampler_model partner (
    .clk(clk), .sampleRequest(sReq), .violate(violate), .sampleDone(sDone),
    .tempLow(tLow), .tempHigh(tHigh), .adcOut(aOut)
  );
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim;
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    v = regRdData;
  endtask
  task automatic cmd(input lrac_cmd_t c);
    @(negedge clk);
    cmdCode = c;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
  endtask
  // Counts low cycles of each indicator after a status request.
  task automatic pulses(input int expIn, input int expOut, input logic outFirst);
    int ni = 0;
    int no = 0;
    logic seen = 1'b0;
    logic first = 1'b0;
    cmd(CMD_SPEC_TEST);
    repeat (100)
    begin
      @(negedge clk);
      ni += int'(!inN);
      no += int'(!outN);
      if (!seen && (!inN || !outN))
      begin
        seen = 1'b1;
        first = !outN;
      end
    end
    chk(ni, expIn);
    chk(no, expOut);
    chk(first, outFirst);
  endtask
  task automatic t_regs;
    logic [7:0] ad [4] = '{8'h00, 8'h03, 8'h0A, 8'h30};
    logic [7:0] ex [4] = '{8'h7F, 8'h07, 8'h87, 8'h00};
    rd(`LRAC_OFS_DAY);
    chk(v, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(ad[i], 8'hFF);
      rd(ad[i]);
      chk(v, ex[i]);
    end
  endtask
  task automatic t_clock(input logic [7:0] h, input logic [7:0] hx);
    int n = 0;
    wr(`LRAC_OFS_HOUR, h);
    wr(`LRAC_OFS_MIN, 8'h59);
    wr(`LRAC_OFS_SEC, 8'h59);
    v = 8'h59;
    while (v === 8'h59 && n < 60)
    begin
      rd(`LRAC_OFS_SEC);
      n++;
    end
    chk(v, 8'h00);
    rd(`LRAC_OFS_MIN);
    chk(v, 8'h00);
    rd(`LRAC_OFS_HOUR);
    chk(v, hx);
  endtask
  task automatic waitIrq;
    int n = 0;
    while (irqN !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_alarm;
    for (int a = 7; a <= 10; a++)
      wr(a[7:0], 8'h80);
    wr(`LRAC_OFS_CTRL1, 8'h01);
    waitIrq();
    chk(irqN, 1'b0);
    wr(`LRAC_OFS_STATUS, 8'h00);
    rd(`LRAC_OFS_STATUS);
    chk(v[0], 1'b0);
    chk(irqN, 1'b1);
    wr(`LRAC_OFS_CTRL1, 8'h00);
    repeat (45) @(negedge clk);
    chk(irqN, 1'b1);
    rd(`LRAC_OFS_STATUS);
    chk(v[0], 1'b1);
    wr(`LRAC_OFS_ASEC, 8'h03);
    wr(`LRAC_OFS_SEC, 8'h01);
    wr(`LRAC_OFS_STATUS, 8'h00);
    wr(`LRAC_OFS_CTRL1, 8'h01);
    waitIrq();
    rd(`LRAC_OFS_SEC);
    chk(v, 8'h03);
    wr(`LRAC_OFS_CTRL1, 8'h00);
  endtask
  task automatic t_mission;
    int n = 0;
    wr(`LRAC_OFS_SEC, 8'h00);
    wr(`LRAC_OFS_RATE, 8'h01);
    rd(`LRAC_OFS_STATUS);
    chk(v[5], 1'b1);
    repeat (100) @(negedge clk);
    pulses(10, 10, 1'b1);
    violate = 1'b1;
    while (logWrEn !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk(logWrAddr, 11'h000);
    chk(n > 2000 && n < 3000, 1);
    wr(`LRAC_OFS_STATUS, 8'h22);
    rd(`LRAC_OFS_STATUS);
    chk(v[5], 1'b1);
    wr(`LRAC_OFS_STATUS, 8'h02);
    rd(`LRAC_OFS_STATUS);
    chk(v[5], 1'b0);
    chk(v[1], 1'b1);
    chk(irqN, 1'b1);
    wr(`LRAC_OFS_CTRL1, 8'h02);
    @(negedge clk);
    chk(irqN, 1'b0);
    violate = 1'b0;
    pulses(0, 20, 1'b1);
  endtask
  task automatic t_arm;
    int n = 0;
    logic [7:0] u;
    wr(`LRAC_OFS_CTRL1, 8'h40);
    cmd(CMD_OTHER);
    rd(`LRAC_OFS_CTRL1);
    chk(v, 8'h00);
    rd(`LRAC_OFS_RATE);
    chk(v, 8'h01);
    wr(`LRAC_OFS_CTRL1, 8'h40);
    cmd(CMD_CLEAR_MEM);
    while (memClr !== 1'b1 && n < 3)
    begin
      @(negedge clk);
      n++;
    end
    chk(memClr, 1'b1);
    rd(`LRAC_OFS_STATUS);
    chk(v[6], 1'b1);
    rd(`LRAC_OFS_RATE);
    chk(v, 8'h00);
    wr(`LRAC_OFS_RATE, 8'h02);
    repeat (100) @(negedge clk);
    wr(`LRAC_OFS_CTRL1, 8'h00);
    rd(`LRAC_OFS_STATUS);
    chk(v[5], 1'b0);
    // Backup with the stop bit parks the seconds; a pin-started mission must wake it again.
    pwrOk = 1'b0;
    wr(`LRAC_OFS_CTRL1, 8'h90);
    chk(osc, 1'b0);
    rd(`LRAC_OFS_SEC);
    u = v;
    repeat (45) @(negedge clk);
    rd(`LRAC_OFS_SEC);
    chk(v, u);
    startN = 1'b0;
    repeat (30) @(negedge clk);
    startN = 1'b1;
    chk(osc, 1'b1);
    rd(`LRAC_OFS_STATUS);
    chk(v[5], 1'b1);
    pwrOk = 1'b1;
  endtask
  initial
  begin
    reset = 1'b1;
    regWrEn = 1'b0;
    cmdValid = 1'b0;
    startN = 1'b1;
    pwrOk = 1'b1;
    violate = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    cmdCode = CMD_OTHER;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_clock(8'h23, 8'h00);
    t_clock(8'h71, 8'h52);
    t_alarm();
    pulses(20, 0, 1'b0);
    t_mission();
    t_arm();
    end_sim();
  end
  initial
  begin
    #400000;
    fails++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
